// >>> hdl/esb_exec_state.sv
// Purpose: Execution-state bits of the combined status word
// Assumes: All event inputs are one-cycle pulses synchronous to CLK
// Notes:   Condition flags and exception number live elsewhere
`timescale 1ns/10ps
`default_nettype none
module esb_exec_state #(
   parameter int COND_LEN = 4
) (
   input  wire logic               CLK,
   input  wire logic               RST,
   input  wire logic               COND_START,
   input  wire logic [7:0]         COND_SETUP,
   input  wire logic               INSTR_DONE,
   input  wire logic               XFER_SUSPEND,
   input  wire logic [3:0]         XFER_NEXT_REG,
   input  wire logic               XFER_RESUME,
   input  wire logic               BRANCH_EXCH,
   input  wire logic               TARGET_BIT0,
   input  wire logic               EXC_ENTRY,
   input  wire logic               VECTOR_BIT0,
   input  wire logic               EXC_RETURN,
   input  wire logic [31:0]        STACKED_WORD,
   input  wire logic               VEC_RD_ACK,
   input  wire logic [31:0]        VEC_RD_DATA,
   input  wire logic               EXEC_REQ,
   input  wire logic               IN_FAULT_HANDLER,
   input  wire logic               RD_REQ,
   input  wire esb_pkg::esb_view_t RD_VIEW,
   input  wire logic               RD_BY_MOVE,
   input  wire logic               WR_REQ,
   output logic                    VEC_RD_REQ,
   output logic [31:0]             VEC_RD_ADDR,
   output logic                    EXEC_GRANT,
   output logic                    FAULT,
   output logic                    LOCKUP,
   output logic                    RESUME_VALID,
   output logic [3:0]              RESUME_REG,
   output logic                    RD_VALID,
   output logic [31:0]             RD_DATA,
   output logic                    WR_DISCARD,
   output logic                    ISA_STATE,
   output logic                    COND_ACTIVE,
   output logic [3:0]              COND_CODE,
   output logic                    XFER_ACTIVE,
   output logic [31:0]             EXEC_WORD
);
   // ----------------------------------------------------------------
   // Elaboration checks
   // ----------------------------------------------------------------
   // The field encoding has exactly four mask slots
   if (COND_LEN != esb_pkg::COND_MAX) begin : g_len_chk
      $error("COND_LEN must equal the four-slot field encoding");
   end

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   typedef enum {ESB_FETCH, ESB_WAIT, ESB_RUN} esb_state_t;
   esb_state_t          state_r;
   logic                isa_r;
   logic [7:0]          field_r, field_nxt;
   logic [31:0]         word_nxt, rd_data_nxt;
   logic                run, susp_ok, resume_ok, start_ok, adv_ok;
   esb_pkg::esb_dec_t   dec;

   assign run       = (state_r == ESB_RUN);
   assign susp_ok   = run && !EXC_ENTRY && !EXC_RETURN && XFER_SUSPEND;
   assign resume_ok = run && !EXC_ENTRY && !EXC_RETURN && !XFER_SUSPEND &&
                      XFER_RESUME && dec.xfer_active;
   // A setup with an empty mask is not a block and is dropped
   assign start_ok  = run && !EXC_ENTRY && !EXC_RETURN && !XFER_SUSPEND &&
                      !resume_ok && COND_START && (COND_SETUP[3:0] != 4'h0);
   assign adv_ok    = run && !EXC_ENTRY && !EXC_RETURN && !XFER_SUSPEND &&
                      !resume_ok && !start_ok && INSTR_DONE &&
                      dec.cond_active;

   esb_field_dec u_dec (
      .field (field_r),
      .dec   (dec)
   );

   esb_view_mux u_mux (
      .word    (word_nxt),
      .view    (RD_VIEW),
      .by_move (RD_BY_MOVE),
      .data    (rd_data_nxt)
   );

   // ----------------------------------------------------------------
   // Reset vector fetch
   // ----------------------------------------------------------------
   // fetch reset vector
   always_ff @(posedge CLK) begin
      if (RST) begin
         state_r     <= ESB_FETCH;
         VEC_RD_REQ  <= 1'b0;
         VEC_RD_ADDR <= esb_pkg::WORD_ZERO;
      end else begin
         case (state_r)
            ESB_FETCH: begin
               VEC_RD_REQ  <= 1'b1;
               VEC_RD_ADDR <= esb_pkg::VECTOR_ADDR;
               state_r     <= ESB_WAIT;
            end
            ESB_WAIT: begin
               if (VEC_RD_ACK) begin
                  VEC_RD_REQ <= 1'b0;
                  state_r    <= ESB_RUN;
               end
            end
            ESB_RUN: begin
               VEC_RD_REQ <= 1'b0;
            end
            default: begin
               state_r <= ESB_FETCH;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Instruction-set state bit
   // ----------------------------------------------------------------
   // resets to one
   always_ff @(posedge CLK) begin
      if (RST) begin
         isa_r <= esb_pkg::ISA_RESET;
      end else if (state_r == ESB_WAIT && VEC_RD_ACK) begin
         isa_r <= VEC_RD_DATA[0];
      end else if (run) begin
         if (EXC_ENTRY) begin
            isa_r <= VECTOR_BIT0;
         end else if (EXC_RETURN) begin
            isa_r <= STACKED_WORD[esb_pkg::ISA_BIT];
         end else if (BRANCH_EXCH) begin
            isa_r <= TARGET_BIT0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Split field
   // ----------------------------------------------------------------
   always_comb begin
      field_nxt = field_r;
      if (run && EXC_ENTRY) begin
         // State has been stacked by the entry sequence
         field_nxt = esb_pkg::FIELD_RESET;
      end else if (run && EXC_RETURN) begin
         field_nxt = {STACKED_WORD[esb_pkg::FLD_LO_MSB:esb_pkg::FLD_LO_LSB],
                      STACKED_WORD[esb_pkg::FLD_HI_MSB:esb_pkg::FLD_HI_LSB]};
      end else if (susp_ok) begin
         field_nxt = {XFER_NEXT_REG, 4'h0};
      end else if (resume_ok) begin
         field_nxt = esb_pkg::FIELD_RESET;
      end else if (start_ok) begin
         field_nxt = COND_SETUP;
      end else if (adv_ok) begin
         if (field_r[2:0] == 3'h0) begin
            field_nxt = esb_pkg::FIELD_RESET;
         end else begin
            field_nxt = {field_r[7:5], field_r[3:0], 1'b0};
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         field_r <= esb_pkg::FIELD_RESET;
      end else begin
         field_r <= field_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Status word and live outputs
   // ----------------------------------------------------------------
   always_comb begin
      word_nxt = esb_pkg::WORD_ZERO;
      word_nxt[esb_pkg::FLD_HI_MSB:esb_pkg::FLD_HI_LSB] = field_r[1:0];
      word_nxt[esb_pkg::FLD_LO_MSB:esb_pkg::FLD_LO_LSB] = field_r[7:2];
      word_nxt[esb_pkg::ISA_BIT] = isa_r;
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         EXEC_WORD   <= esb_pkg::WORD_RESET;
         ISA_STATE   <= esb_pkg::ISA_RESET;
         COND_ACTIVE <= 1'b0;
         COND_CODE   <= 4'h0;
         XFER_ACTIVE <= 1'b0;
      end else begin
         EXEC_WORD   <= word_nxt & ~esb_pkg::RSVD_MASK;
         ISA_STATE   <= isa_r;
         COND_ACTIVE <= dec.cond_active;
         COND_CODE   <= dec.cond_active ? dec.cond_code : 4'h0;
         XFER_ACTIVE <= dec.xfer_active;
      end
   end

   // ----------------------------------------------------------------
   // Execution gate
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         EXEC_GRANT <= 1'b0;
         FAULT      <= 1'b0;
         LOCKUP     <= 1'b0;
      end else begin
         EXEC_GRANT <= run && EXEC_REQ && isa_r && !LOCKUP;
         FAULT      <= run && EXEC_REQ && !isa_r && !IN_FAULT_HANDLER &&
                       !LOCKUP;
         // Lockup is left only by reset
         if (run && EXEC_REQ && !isa_r && IN_FAULT_HANDLER) begin
            LOCKUP <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Resume answer and status access
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         RESUME_VALID <= 1'b0;
         RESUME_REG   <= 4'h0;
      end else begin
         RESUME_VALID <= resume_ok;
         RESUME_REG   <= resume_ok ? dec.resume_reg : 4'h0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         RD_VALID   <= 1'b0;
         RD_DATA    <= esb_pkg::WORD_ZERO;
         WR_DISCARD <= 1'b0;
      end else begin
         RD_VALID   <= RD_REQ;
         RD_DATA    <= RD_REQ ? rd_data_nxt : esb_pkg::WORD_ZERO;
         WR_DISCARD <= WR_REQ;
      end
   end
   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   sequence s_start_one;
      start_ok && (COND_SETUP[3:0] == 4'h1);
   endsequence
   sequence s_four_steps;
      (INSTR_DONE && !COND_START && !EXC_ENTRY && !EXC_RETURN &&
       !XFER_SUSPEND && !XFER_RESUME) [*4];
   endsequence
   AST_FIELD_MAP: assert property (
      ##1 EXEC_WORD[15:10] == $past(field_r[7:2]) &&
          EXEC_WORD[26:25] == $past(field_r[1:0]))
      else $error("split field not placed in status word");
   AST_RESUME_HI_ZERO: assert property (
      dec.xfer_active |=> EXEC_WORD[26:25] == 2'h0 && XFER_ACTIVE)
      else $error("resume form with bits 26:25 set");
   AST_RESUME_LO_ZERO: assert property (
      susp_ok |=> field_r[3:0] == 4'h0 ##1 EXEC_WORD[11:10] == 2'h0)
      else $error("resume form with bits 11:10 set");
   AST_COND_FOUR: assert property (
      s_start_one ##1 s_four_steps |=> !dec.cond_active)
      else $error("conditional block outlived four instructions");
   AST_SUSPEND_REC: assert property (
      susp_ok |=> dec.resume_reg == $past(XFER_NEXT_REG) && !dec.cond_active)
      else $error("next register not recorded on suspend");
   AST_RESUME_REG: assert property (
      resume_ok |=> RESUME_VALID && RESUME_REG == $past(dec.resume_reg)
                    ##1 !XFER_ACTIVE)
      else $error("resume register not reported");
   AST_ISA_RESET: assert property (
      $fell(RST) |-> ISA_STATE && EXEC_WORD == esb_pkg::WORD_RESET)
      else $error("instruction-set bit not one after reset");
   AST_ISA_BRANCH: assert property (
      run && BRANCH_EXCH && !EXC_ENTRY && !EXC_RETURN
      |=> isa_r == $past(TARGET_BIT0) ##1 ISA_STATE == $past(isa_r))
      else $error("branch did not update instruction-set bit");
   AST_FAULT: assert property (
      run && EXEC_REQ && !isa_r && !LOCKUP |=> !EXEC_GRANT &&
      FAULT != $past(IN_FAULT_HANDLER) && LOCKUP == $past(IN_FAULT_HANDLER))
      else $error("execution with clear bit not trapped");
   AST_RSVD_ZERO: assert property (
      ((RD_DATA | EXEC_WORD) & esb_pkg::RSVD_MASK) == esb_pkg::WORD_ZERO)
      else $error("reserved bit reads nonzero");
   AST_VIEW_HIDE: assert property (
      RD_REQ && RD_VIEW != esb_pkg::VIEW_FULL &&
      RD_VIEW != esb_pkg::VIEW_EXEC |=> RD_VALID && RD_DATA == 32'h0)
      else $error("execution bits exposed in a combined view");
   AST_MOVE_ZERO: assert property (
      RD_REQ && RD_BY_MOVE |=> RD_VALID && RD_DATA == 32'h0)
      else $error("status-move read returned execution bits");
   AST_VEC_FETCH: assert property (
      $fell(RST) |-> ##1 VEC_RD_REQ && VEC_RD_ADDR == esb_pkg::VECTOR_ADDR)
      else $error("reset vector fetch not issued");
   AST_ZERO_IDLE: assert property (
      field_r == 8'h00 |=> !COND_ACTIVE && !XFER_ACTIVE)
      else $error("zero field reported active");
endmodule
`default_nettype wire

// >>> hdl/esb_field_dec.sv
// Purpose: Decodes the split field into block and transfer state
// Assumes: Field byte is {bits 15:10, bits 26:25} of the status word
// Notes:   Purely combinational
`timescale 1ns/10ps
`default_nettype none
module esb_field_dec (
   input  wire logic [7:0]       field,
   output esb_pkg::esb_dec_t     dec
);
   always_comb begin
      dec             = '0;
      dec.cond_code   = field[7:4];
      // Low nibble nonzero marks a live conditional block
      dec.cond_active = (field[3:0] != 4'h0);
      // Resume form keeps the low nibble clear; all zero means idle
      dec.xfer_active = (field[3:0] == 4'h0) && (field[7:4] != 4'h0);
      dec.resume_reg  = field[7:4];
      // Lowest set mask bit tells how many block slots remain
      case (1'b1)
         field[0]: dec.cond_left = 3'h4;
         field[1]: dec.cond_left = 3'h3;
         field[2]: dec.cond_left = 3'h2;
         field[3]: dec.cond_left = 3'h1;
         default:  dec.cond_left = 3'h0;
      endcase
   end
endmodule
`default_nettype wire

// >>> hdl/esb_pkg.sv
// Purpose: Shared constants and types for the execution-state bits block
// Assumes: 32-bit combined status word, field bits as laid out below
// Notes:   Split field is carried internally as one byte, see FLD_* below
package esb_pkg;
   // -----------------------------------------------------------------
   // Bit positions in the combined status word
   // -----------------------------------------------------------------
   localparam int          ISA_BIT     = 24;
   localparam int          FLD_HI_MSB  = 26;
   localparam int          FLD_HI_LSB  = 25;
   localparam int          FLD_LO_MSB  = 15;
   localparam int          FLD_LO_LSB  = 10;
   localparam int          RESUME_REG_MSB = 15;
   localparam int          RESUME_REG_LSB = 12;
   localparam int          FIELD_W     = 8;
   localparam int          COND_MAX    = 4;

   // -----------------------------------------------------------------
   // Values after reset and fixed addresses
   // -----------------------------------------------------------------
   localparam logic [31:0] WORD_RESET  = 32'h0100_0000;
   localparam logic [31:0] VECTOR_ADDR = 32'h0000_0004;
   localparam logic [31:0] RSVD_MASK   = 32'h00FF_03C0;
   localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
   localparam logic        ISA_RESET   = 1'b1;
   localparam logic [7:0]  FIELD_RESET = 8'h00;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [2:0] {
      VIEW_FULL,
      VIEW_EXEC,
      VIEW_INT_EXEC,
      VIEW_APP_INT,
      VIEW_APP_EXEC,
      VIEW_APP,
      VIEW_INT
   } esb_view_t;

   typedef struct packed {
      logic       cond_active;
      logic       xfer_active;
      logic [3:0] cond_code;
      logic [2:0] cond_left;
      logic [3:0] resume_reg;
   } esb_dec_t;
endpackage

// >>> hdl/esb_view_mux.sv
// Purpose: Builds the read answer for one status-word view
// Assumes: Only execution-state bits are present in the word given
// Notes:   Combinational; reserved bits always forced low
`timescale 1ns/10ps
`default_nettype none
module esb_view_mux (
   input  wire logic [31:0]      word,
   input  wire esb_pkg::esb_view_t view,
   input  wire logic             by_move,
   output logic [31:0]           data
);
   logic exposed;

   always_comb begin
      exposed = !by_move &&
                ((view == esb_pkg::VIEW_FULL) ||
                 (view == esb_pkg::VIEW_EXEC));
      data    = exposed ? (word & ~esb_pkg::RSVD_MASK) : esb_pkg::WORD_ZERO;
   end
endmodule
`default_nettype wire

// >>> verif/esb_exec_state_tb.sv
// Purpose: Self-checking bench for the execution-state bits block
// Assumes: Expected words are built from the split-field layout here
// Notes:   Pulse results are matched against queued notes at negedge
`timescale 1ns/10ps
`default_nettype none
module esb_exec_state_tb;
   logic        clk, rst, cond_start, instr_done, xfer_suspend;
   logic        xfer_resume, branch_exch, target_bit0, exc_entry;
   logic        vector_bit0, exc_return, vec_rd_ack, exec_req;
   logic        in_fault_handler, rd_req, rd_by_move, wr_req;
   logic [7:0]  cond_setup, fld;
   logic [3:0]  xfer_next_reg, resume_reg, cond_code;
   logic [31:0] stacked_word, vec_rd_data, vec_rd_addr, rd_data, exec_word;
   logic        vec_rd_req, exec_grant, fault, lockup, resume_valid, isa;
   logic        rd_valid, wr_discard, isa_state, cond_active, xfer_active;
   esb_pkg::esb_view_t rd_view;
   int          mismatches, cmp_count, wr_pend;
   logic [31:0] q_rd[$];
   logic [3:0]  q_res[$];
   logic [1:0]  q_ex[$];

   esb_exec_state #(.COND_LEN(4)) u_dut (
      .CLK(clk), .RST(rst), .COND_START(cond_start),
      .COND_SETUP(cond_setup), .INSTR_DONE(instr_done),
      .XFER_SUSPEND(xfer_suspend), .XFER_NEXT_REG(xfer_next_reg),
      .XFER_RESUME(xfer_resume), .BRANCH_EXCH(branch_exch),
      .TARGET_BIT0(target_bit0), .EXC_ENTRY(exc_entry),
      .VECTOR_BIT0(vector_bit0), .EXC_RETURN(exc_return),
      .STACKED_WORD(stacked_word), .VEC_RD_ACK(vec_rd_ack),
      .VEC_RD_DATA(vec_rd_data), .EXEC_REQ(exec_req),
      .IN_FAULT_HANDLER(in_fault_handler), .RD_REQ(rd_req),
      .RD_VIEW(rd_view), .RD_BY_MOVE(rd_by_move), .WR_REQ(wr_req),
      .VEC_RD_REQ(vec_rd_req), .VEC_RD_ADDR(vec_rd_addr),
      .EXEC_GRANT(exec_grant), .FAULT(fault), .LOCKUP(lockup),
      .RESUME_VALID(resume_valid), .RESUME_REG(resume_reg),
      .RD_VALID(rd_valid), .RD_DATA(rd_data), .WR_DISCARD(wr_discard),
      .ISA_STATE(isa_state), .COND_ACTIVE(cond_active),
      .COND_CODE(cond_code), .XFER_ACTIVE(xfer_active),
      .EXEC_WORD(exec_word));

   // ---------------------------------------------------------------
   // Clock, helpers and checks
   // ---------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   function automatic logic [31:0] word_of(input logic i,
                                           input logic [7:0] f);
      return {5'h00, f[1:0], i, 8'h00, f[7:2], 10'h000};
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wrap_up;
      $display("Counts: %0d compares, %0d mismatches", cmp_count,
               mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Every pulse must match a queued note; a stray pulse is a mismatch
   always @(negedge clk) begin
      if (rst === 1'b0) begin
         if (rd_valid === 1'b1) begin
            if (q_rd.size() == 0) check(32'h1, 32'h0);
            else check(rd_data, q_rd.pop_front());
         end
         if (resume_valid === 1'b1) begin
            if (q_res.size() == 0) check(32'h1, 32'h0);
            else check({28'h0, resume_reg}, {28'h0, q_res.pop_front()});
         end
         if (exec_grant === 1'b1 || fault === 1'b1) begin
            if (q_ex.size() == 0) check(32'h1, 32'h0);
            else check({30'h0, exec_grant, fault},
                       {30'h0, q_ex.pop_front()});
         end
         if (wr_discard === 1'b1) begin
            check({31'h0, wr_discard}, {31'h0, wr_pend > 0});
            if (wr_pend > 0) wr_pend--;
         end
      end
   end

   // ---------------------------------------------------------------
   // Bench tasks
   // ---------------------------------------------------------------
   task automatic do_reset;
      int n;
      rst = 1'b1;
      step(6);
      check(exec_word, esb_pkg::WORD_RESET);
      check({31'h0, lockup}, 32'h0);
      rst = 1'b0;
      step(1);
      check({vec_rd_addr[31:1], vec_rd_req}, 32'h5);
      vec_rd_data = $urandom | 32'h1;
      n = 0;
      while (vec_rd_req !== 1'b1) begin
         if (n == 20) begin
            mismatches++;
            wrap_up();
         end
         n++;
         step(1);
      end
      vec_rd_ack = 1'b1;
      step(1);
      vec_rd_ack = 1'b0;
      step(2);
      isa = 1'b1;
      fld = 8'h00;
      check({31'h0, isa_state}, 32'h1);
   endtask

   task automatic read_all;
      logic [31:0] w;
      for (int v = 0; v < 7; v++) begin
         for (int m = 0; m < 2; m++) begin
            rd_view = esb_pkg::esb_view_t'(v);
            rd_by_move = m[0];
            w = ((rd_view == esb_pkg::VIEW_FULL ||
                  rd_view == esb_pkg::VIEW_EXEC) && m == 0) ?
                word_of(isa, fld) : 32'h0;
            q_rd.push_back(w);
            rd_req = 1'b1;
            step(1);
         end
      end
      rd_req = 1'b0;
      wr_pend++;
      wr_req = 1'b1;
      step(1);
      wr_req = 1'b0;
      step(2);
      check(exec_word, word_of(isa, fld));
   endtask

   task automatic cond_test(input int n);
      logic [7:0] s;
      s[7:4] = 4'($urandom_range(14));
      s[3:0] = 4'(($urandom << (5 - n)) | (1 << (4 - n)));
      cond_setup = s;
      cond_start = 1'b1;
      step(1);
      cond_start = 1'b0;
      fld = s;
      step(1);
      check({27'h0, cond_active, cond_code}, {28'h1, s[7:4]});
      check(exec_word, word_of(isa, fld));
      for (int i = 1; i <= n; i++) begin
         instr_done = 1'b1;
         step(1);
         instr_done = 1'b0;
         step(1);
         check({31'h0, cond_active}, {31'h0, i < n});
      end
      fld = 8'h00;
      check(exec_word, word_of(isa, fld));
   endtask

   task automatic xfer_test;
      logic [3:0] r;
      r = 4'($urandom_range(15, 1));
      xfer_next_reg = r;
      xfer_suspend = 1'b1;
      step(1);
      xfer_suspend = 1'b0;
      fld = {r, 4'h0};
      step(1);
      check({31'h0, xfer_active}, 32'h1);
      check(exec_word, word_of(isa, fld));
      q_res.push_back(r);
      // Second resume finds no live transfer and must stay silent
      xfer_resume = 1'b1;
      step(2);
      xfer_resume = 1'b0;
      fld = 8'h00;
      step(2);
      check({31'h0, xfer_active}, 32'h0);
   endtask

   task automatic exec_op(input logic noted);
      if (noted) q_ex.push_back(isa ? 2'b10 : 2'b01);
      exec_req = 1'b1;
      step(1);
      exec_req = 1'b0;
      step(1);
   endtask

   task automatic branch(input logic b);
      target_bit0 = b;
      branch_exch = 1'b1;
      step(1);
      branch_exch = 1'b0;
      isa = b;
      step(1);
      check({31'h0, isa_state}, {31'h0, b});
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      rst = 1'b1;
      {cond_start, instr_done, xfer_suspend, xfer_resume} = '0;
      {branch_exch, target_bit0, exc_entry, vector_bit0} = '0;
      {exc_return, vec_rd_ack, exec_req, in_fault_handler} = '0;
      {rd_req, rd_by_move, wr_req} = '0;
      {cond_setup, xfer_next_reg, stacked_word, vec_rd_data} = '0;
      rd_view = esb_pkg::VIEW_FULL;
      {mismatches, cmp_count, wr_pend} = '0;
      void'($urandom(66607));
      do_reset();
      $display("test reset done");
      read_all();
      $display("test views done");
      for (int n = 1; n <= 4; n++) cond_test(n);
      cond_setup = 8'h30;
      cond_start = 1'b1;
      step(1);
      cond_start = 1'b0;
      step(1);
      check({30'h0, cond_active, xfer_active}, 32'h0);
      check(exec_word, word_of(isa, fld));
      // Four back-to-back steps must end a block with the longest mask
      cond_setup = {4'($urandom_range(14)), 4'h1};
      cond_start = 1'b1;
      step(1);
      cond_start = 1'b0;
      instr_done = 1'b1;
      step(3);
      check({31'h0, cond_active}, 32'h1);
      step(1);
      instr_done = 1'b0;
      step(2);
      check({31'h0, cond_active}, 32'h0);
      $display("test block done");
      xfer_test();
      $display("test transfer done");
      exec_op(1'b1);
      branch(1'b0);
      exec_op(1'b1);
      branch(1'b1);
      exec_op(1'b1);
      stacked_word = $urandom & 32'hFEFF_FFFF;
      fld = {stacked_word[15:10], stacked_word[26:25]};
      exc_return = 1'b1;
      step(1);
      exc_return = 1'b0;
      isa = 1'b0;
      step(1);
      check(exec_word, word_of(isa, fld));
      read_all();
      exec_op(1'b1);
      vector_bit0 = 1'b1;
      exc_entry = 1'b1;
      step(1);
      exc_entry = 1'b0;
      {isa, fld} = 9'h100;
      step(1);
      check(exec_word, esb_pkg::WORD_RESET);
      check({30'h0, cond_active, xfer_active}, 32'h0);
      $display("test isa done");
      branch(1'b0);
      in_fault_handler = 1'b1;
      exec_op(1'b0);
      step(1);
      check({31'h0, lockup}, 32'h1);
      in_fault_handler = 1'b0;
      branch(1'b1);
      exec_op(1'b0);
      check({31'h0, lockup}, 32'h1);
      do_reset();
      $display("test lockup done");
      check(32'(q_rd.size() + q_res.size() + q_ex.size() + wr_pend),
            32'h0);
      wrap_up();
   end

   initial begin
      #2_000_000;
      mismatches++;
      wrap_up();
   end
endmodule
`default_nettype wire
